// file: verilog/ccrb_regs.vh
// offsets, reset values and field positions of the converter config bank
`ifndef CCRB_REGS_VH
`define CCRB_REGS_VH

`define CCRB_ADDR_W            8
`define CCRB_DATA_W            8
`define CCRB_NUM_BYTE_REGS     14

`define CCRB_FS_HI_OFF         8'h32
`define CCRB_FS_LO_OFF         8'h33
`define CCRB_REF_BYP_OFF       8'h38
`define CCRB_TSTAMP_OFF        8'h3B
`define CCRB_PREEMPH_OFF       8'h48
`define CCRB_SER_LAST_OFF      8'h5F
`define CCRB_INSEL_OFF         8'h60
`define CCRB_CAL_EN_OFF        8'h61
`define CCRB_CALIBRATION_CONFIG_ZERO_OFF      8'h62
`define CCRB_CAL_STATE_OFF     8'h6A
`define CCRB_CAL_PIN_OFF       8'h6B
`define CCRB_CAL_TRIG_OFF      8'h6C
`define CCRB_LOW_POWER_BACKGROUND_CALIBRATION_OFF        8'h6E
`define CCRB_CAL_WEN_OFF       8'h70
`define CCRB_CAL_WORD_OFF      8'h71
`define CCRB_GAIN_A_OFF        8'h7A
`define CCRB_GAIN_B_OFF        8'h7B
`define CCRB_CAL_LAST_OFF      8'hFF

`define CCRB_FS_RESET          16'hA000
`define CCRB_FS_MIN_RECOMMEND  16'h2000
`define CCRB_ZERO_RESET        8'h00
`define CCRB_ONE_RESET         8'h01
`define CCRB_LOW_POWER_BACKGROUND_CALIBRATION_RESET      8'h88
`define CCRB_UNDEF_RESET       8'h00

`define CCRB_REF_BYP_BIT       0
`define CCRB_TS_RECV_BIT       0
`define CCRB_TS_LVPECL_BIT     1
`define CCRB_PREEMPH_MSB       3
`define CCRB_PREEMPH_LSB       0
`define CCRB_CAL_WEN_BIT       0

`endif

// file: verilog/ccrb_byte_reg.v
// one read-write byte register with address match and reset value
module ccrb_byte_reg #(
  parameter [7:0] REG_ADDR  = 8'h00,
  parameter [7:0] RESET_VAL = 8'h00
) (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       wrEn,
  input  wire [7:0] addr,
  input  wire [7:0] wrData,
  output wire       hit,
  output wire [7:0] value
);

  reg  [7:0] value_reg;
  wire [7:0] value_next;

  assign hit        = (addr == REG_ADDR);
  assign value_next = (wrEn && hit) ? wrData : value_reg;
  assign value      = value_reg;

  always @(posedge ref_clk) begin
    if (rst) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

endmodule // ccrb_byte_reg

// file: verilog/ccrb_reg_bank.v
// converter configuration register bank with a plain register port
// Functional notes
// - second input full-scale code is 16-bit read-write, reset 0xA000.
// - reference bypass 0x038 resets zero; bit 0 selects core supply rail.
// - timestamp control 0x03B bit 1 selects low-voltage PECL, resets zero.
// - timestamp control bit 0 enables receiver; bits 7 to 2 reset zero.
// - pre-emphasis 0x048 bits 3:0 drive all 4 serial lanes together.
// - serializer group spans 0x048-0x05F; only pre-emphasis is defined.
// - calibration group spans 0x060-0x0FF; unassigned addresses reserved.
// - input selector, calibration enable and config zero reset to 0x01.
// - calibration status register sits at 0x06A.
// - calibration pin setup 0x06B resets 0x00; trigger 0x06C resets 0x01.
// - low-power background calibration at 0x06E resets to 0x88.
// - word access enable 0x070 resets 0x00; word port sits at 0x071.
// - channel A and B gain adjust registers at 0x07A and 0x07B.
// - full-scale code occupies byte addresses 0x032 and 0x033.
//
// The address-and-strobe port was chosen for this implementation.
`include "ccrb_regs.vh"

module ccrb_reg_bank (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [7:0]  addr,
  input  wire [7:0]  wrData,
  input  wire        wrEn,
  input  wire        rdEn,
  output wire [7:0]  rdData,
  output wire [15:0] secondInputFullscaleCode,
  output wire        fullscaleBelowRecommended,
  output wire        referenceBypassBit,
  output wire        timestampReceiverEnable,
  output wire        timestampLowVoltagePeclSelect,
  output wire [15:0] lanePreemphasisLevel,
  output wire [7:0]  inputSelector,
  output wire [7:0]  calibrationEnable,
  output wire [7:0]  calibrationConfigZero,
  output wire [7:0]  calibrationPinSetup,
  output wire [7:0]  calibrationSwTrigger,
  output wire [7:0]  lowPowerBackgroundCalibration,
  output wire        calibrationWordAccessEnable,
  output wire [7:0]  channelAGainAdjust,
  output wire [7:0]  channelBGainAdjust,
  input  wire [7:0]  calibrationStateIn,
  input  wire [7:0]  calibrationWordIn,
  output wire [7:0]  calibrationWordOut,
  output wire        calibrationWordWrite,
  output wire        calibrationWordRead
);

  localparam NREG = `CCRB_NUM_BYTE_REGS;
  // high byte lives at the lower address, so it takes the lower entry
  localparam [15:0] FS_RESET = `CCRB_FS_RESET;

  // register index order, low index in the low byte of each vector
  localparam [8*NREG-1:0] REG_ADDRS = {
    `CCRB_GAIN_B_OFF,   `CCRB_GAIN_A_OFF,   `CCRB_CAL_WEN_OFF,
    `CCRB_LOW_POWER_BACKGROUND_CALIBRATION_OFF,   `CCRB_CAL_TRIG_OFF, `CCRB_CAL_PIN_OFF,
    `CCRB_CALIBRATION_CONFIG_ZERO_OFF, `CCRB_CAL_EN_OFF,   `CCRB_INSEL_OFF,
    `CCRB_PREEMPH_OFF,  `CCRB_TSTAMP_OFF,   `CCRB_REF_BYP_OFF,
    `CCRB_FS_LO_OFF,    `CCRB_FS_HI_OFF
  };

  localparam [8*NREG-1:0] REG_RESETS = {
    `CCRB_UNDEF_RESET,  `CCRB_UNDEF_RESET,  `CCRB_ZERO_RESET,
    `CCRB_LOW_POWER_BACKGROUND_CALIBRATION_RESET, `CCRB_ONE_RESET,    `CCRB_ZERO_RESET,
    `CCRB_ONE_RESET,    `CCRB_ONE_RESET,    `CCRB_ONE_RESET,
    `CCRB_ZERO_RESET,   `CCRB_ZERO_RESET,   `CCRB_ZERO_RESET,
    FS_RESET[7:0],      FS_RESET[15:8]
  };

  localparam IDX_FS_HI   = 0;
  localparam IDX_FS_LO   = 1;
  localparam IDX_REF_BYP = 2;
  localparam IDX_TSTAMP  = 3;
  localparam IDX_PREEMPH = 4;
  localparam IDX_INSEL   = 5;
  localparam IDX_CAL_EN  = 6;
  localparam IDX_CFG0    = 7;
  localparam IDX_PIN     = 8;
  localparam IDX_TRIG    = 9;
  localparam IDX_LP      = 10;
  localparam IDX_WEN     = 11;
  localparam IDX_GAIN_A  = 12;
  localparam IDX_GAIN_B  = 13;

  wire [8*NREG-1:0] regValues;
  wire [NREG-1:0]   regHits;
  wire [7:0]        stateHold_next;
  wire              wordPortHit;
  wire              stateHit;
  wire              wordAccessOn;
  reg  [7:0]        readMux;
  reg  [7:0]        rdData_reg;
  reg  [7:0]        stateHold_reg;
  reg  [7:0]        wordOut_reg;
  reg               wordWrite_reg;
  reg               wordRead_reg;
  integer           k;

  // each byte register decodes its own address, so reserved ones never latch
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : gen_regs
      ccrb_byte_reg #(
        .REG_ADDR  (REG_ADDRS[8*g +: 8]),
        .RESET_VAL (REG_RESETS[8*g +: 8])
      ) u_reg (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wrEn    (wrEn),
        .addr    (addr),
        .wrData  (wrData),
        .hit     (regHits[g]),
        .value   (regValues[8*g +: 8])
      );
    end
  endgenerate

  // high byte at the lower address, low byte right after it
  assign secondInputFullscaleCode = {regValues[8*IDX_FS_HI +: 8],
                                     regValues[8*IDX_FS_LO +: 8]};
  // status hint only; the bank stores whatever software writes
  assign fullscaleBelowRecommended =
    (secondInputFullscaleCode < `CCRB_FS_MIN_RECOMMEND);

  assign referenceBypassBit =
    regValues[8*IDX_REF_BYP + `CCRB_REF_BYP_BIT];
  assign timestampReceiverEnable =
    regValues[8*IDX_TSTAMP + `CCRB_TS_RECV_BIT];
  assign timestampLowVoltagePeclSelect =
    regValues[8*IDX_TSTAMP + `CCRB_TS_LVPECL_BIT];

  // one 4-bit field fans out to all four lanes of the 16-bit output
  generate
    for (g = 0; g < 16; g = g + 1) begin : gen_lanes
      assign lanePreemphasisLevel[g] =
        regValues[8*IDX_PREEMPH + `CCRB_PREEMPH_LSB + (g % 4)];
    end
  endgenerate

  assign inputSelector                 = regValues[8*IDX_INSEL +: 8];
  assign calibrationEnable             = regValues[8*IDX_CAL_EN +: 8];
  assign calibrationConfigZero         = regValues[8*IDX_CFG0 +: 8];
  assign calibrationPinSetup           = regValues[8*IDX_PIN +: 8];
  assign calibrationSwTrigger          = regValues[8*IDX_TRIG +: 8];
  assign lowPowerBackgroundCalibration = regValues[8*IDX_LP +: 8];
  assign channelAGainAdjust            = regValues[8*IDX_GAIN_A +: 8];
  assign channelBGainAdjust            = regValues[8*IDX_GAIN_B +: 8];

  assign wordAccessOn = regValues[8*IDX_WEN + `CCRB_CAL_WEN_BIT];
  assign calibrationWordAccessEnable = wordAccessOn;

  assign wordPortHit = (addr == `CCRB_CAL_WORD_OFF);
  assign stateHit    = (addr == `CCRB_CAL_STATE_OFF);

  // status is sampled every cycle so the read shows a stable copy
  assign stateHold_next = calibrationStateIn;

  // reserved addresses in 0x049-0x05F and 0x060-0x0FF fall to zero
  always @* begin
    readMux = 8'h00;
    for (k = 0; k < NREG; k = k + 1) begin
      if (regHits[k]) begin
        readMux = regValues[8*k +: 8];
      end
    end
    if (stateHit) begin
      readMux = stateHold_reg;
    end
    if (wordPortHit && wordAccessOn) begin
      readMux = calibrationWordIn;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rdData_reg    <= 8'h00;
      stateHold_reg <= 8'h00;
      wordOut_reg   <= 8'h00;
      wordWrite_reg <= 1'b0;
      wordRead_reg  <= 1'b0;
    end else begin
      // read data stand for exactly one cycle
      rdData_reg    <= rdEn ? readMux : 8'h00;
      stateHold_reg <= stateHold_next;
      wordWrite_reg <= wrEn && wordPortHit && wordAccessOn;
      wordRead_reg  <= rdEn && wordPortHit && wordAccessOn;
      if (wrEn && wordPortHit && wordAccessOn) begin
        wordOut_reg <= wrData;
      end
    end
  end

  assign rdData               = rdData_reg;
  assign calibrationWordOut   = wordOut_reg;
  assign calibrationWordWrite = wordWrite_reg;
  assign calibrationWordRead  = wordRead_reg;

endmodule // ccrb_reg_bank

// file: sim/ccrb_reg_bank_properties.sv
// port assertions for the converter config bank
module ccrb_reg_bank_properties (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wrData,
  input wire logic        wrEn,
  input wire logic        rdEn,
  input wire logic [7:0]  rdData,
  input wire logic [15:0] secondInputFullscaleCode,
  input wire logic        referenceBypassBit,
  input wire logic        timestampReceiverEnable,
  input wire logic        timestampLowVoltagePeclSelect,
  input wire logic [15:0] lanePreemphasisLevel,
  input wire logic        calibrationWordAccessEnable,
  input wire logic        calibrationWordWrite,
  input wire logic        calibrationWordRead
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_fs_high_byte: assert property (wrEn && addr == 8'h32 |=>
    secondInputFullscaleCode[15:8] == $past(wrData)) else $error("fs high");
  a_fs_low_byte: assert property (wrEn && addr == 8'h33 |=>
    secondInputFullscaleCode[7:0] == $past(wrData)) else $error("fs low");
  a_bypass_bit: assert property (wrEn && addr == 8'h38 |=>
    referenceBypassBit == $past(wrData[0])) else $error("bypass bit");
  a_ts_receiver: assert property (wrEn && addr == 8'h3B |=>
    timestampReceiverEnable == $past(wrData[0])) else $error("ts rx");
  a_ts_pecl: assert property (wrEn && addr == 8'h3B |=>
    timestampLowVoltagePeclSelect == $past(wrData[1])) else $error("ts pecl");
  a_lane_global: assert property (wrEn && addr == 8'h48 |=>
    lanePreemphasisLevel == {4{$past(wrData[3:0])}}) else $error("lanes");
  a_ser_reserved: assert property (rdEn && addr > 8'h48 &&
    addr < 8'h60 |=> rdData == 8'h00) else $error("serial reserved read");
  a_cal_reserved: assert property (rdEn && addr > 8'h7B |=>
    rdData == 8'h00) else $error("cal reserved read");
  a_word_gate: assert property (wrEn && addr == 8'h71 &&
    !calibrationWordAccessEnable |=> !calibrationWordWrite)
    else $error("gate");
  a_word_rd_gate: assert property (rdEn && addr == 8'h71 &&
    !calibrationWordAccessEnable |=> !calibrationWordRead)
    else $error("read gate");
endmodule // ccrb_reg_bank_properties

bind ccrb_reg_bank ccrb_reg_bank_properties u_props (.ref_clk(ref_clk),
  .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
  .rdData(rdData), .secondInputFullscaleCode(secondInputFullscaleCode),
  .referenceBypassBit(referenceBypassBit),
  .timestampReceiverEnable(timestampReceiverEnable),
  .timestampLowVoltagePeclSelect(timestampLowVoltagePeclSelect),
  .lanePreemphasisLevel(lanePreemphasisLevel),
  .calibrationWordAccessEnable(calibrationWordAccessEnable),
  .calibrationWordWrite(calibrationWordWrite),
  .calibrationWordRead(calibrationWordRead));

// file: sim/ccrb_reg_bank_tb.sv
// self-checking bench for the converter config register bank
module ccrb_reg_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, wrEn, rdEn, fsLow, byp, tsRx, tsLv;
  logic        wAcc, wWr, wRd;
  logic [7:0]  addr, wrData, rdData, stIn, wIn, wOut, inSel, calEn, cfg0;
  logic [7:0]  pinSet, swTrig, lpCal, gainA, gainB;
  logic [15:0] fsCode, lane, lfsr, fsTry;
  logic [63:0] fsCodes = 64'h1FFF_2000_FFFF_A000;
  logic [7:0]  mdl [0:255];
  int          errCount = 0, nChecks = 0, cyc = 0;
  ccrb_reg_bank dut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .secondInputFullscaleCode(fsCode), .fullscaleBelowRecommended(fsLow),
    .referenceBypassBit(byp), .timestampReceiverEnable(tsRx),
    .timestampLowVoltagePeclSelect(tsLv), .lanePreemphasisLevel(lane),
    .inputSelector(inSel), .calibrationEnable(calEn),
    .calibrationConfigZero(cfg0), .calibrationPinSetup(pinSet),
    .calibrationSwTrigger(swTrig), .lowPowerBackgroundCalibration(lpCal),
    .calibrationWordAccessEnable(wAcc), .channelAGainAdjust(gainA),
    .channelBGainAdjust(gainB), .calibrationStateIn(stIn),
    .calibrationWordIn(wIn), .calibrationWordOut(wOut),
    .calibrationWordWrite(wWr), .calibrationWordRead(wRd));
  task chk(input string n, input logic [31:0] e, g);
    nChecks++;
    if (g !== e) begin
      errCount++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task conclude;
    if (errCount == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // only these offsets store data; all others read back zero except status 0x6A and word port 0x71
  function automatic bit rw(input logic [7:0] a);
    return a inside {8'h32, 8'h33, 8'h38, 8'h3B, 8'h48, 8'h60, 8'h61,
      8'h62, 8'h6B, 8'h6C, 8'h6E, 8'h70, 8'h7A, 8'h7B};
  endfunction
  task doReset;
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (mdl[i]) mdl[i] = (i == 8'h32) ? 8'hA0 : (i == 8'h6E) ? 8'h88 :
      (i inside {8'h60, 8'h61, 8'h62, 8'h6C}) ? 8'h01 : 8'h00;
    #1;
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge ref_clk);
    wrEn <= 1'b0;
    if (rw(a)) mdl[a] = d;
    // outputs settle in this edge's update; callers look afterwards
    #1;
  endtask
  task rd(input logic [7:0] a);
    logic [7:0] e;
    e = (a == 8'h6A) ? stIn : (a != 8'h71) ? mdl[a] : mdl[8'h70][0] ? wIn : 0;
    @(posedge ref_clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    #1;
    chk("rdData", 32'(e), 32'(rdData));
  endtask
  task outs;
    logic [15:0] f;
    f = {mdl[8'h32], mdl[8'h33]};
    chk("fs", {15'h0, f < 16'h2000, f}, {15'h0, fsLow, fsCode});
    chk("bits", {mdl[8'h38][0], mdl[8'h3B][1:0], mdl[8'h70][0]},
      {byp, tsLv, tsRx, wAcc});
    chk("lanes", 32'({4{mdl[8'h48][3:0]}}), 32'(lane));
    chk("cal", {mdl[8'h60], mdl[8'h61], mdl[8'h62], mdl[8'h6B]},
      {inSel, calEn, cfg0, pinSet});
    chk("trim", {mdl[8'h6C], mdl[8'h6E], mdl[8'h7A], mdl[8'h7B]},
      {swTrig, lpCal, gainA, gainB});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // hang guard: the full sequence needs well under 4000 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errCount++;
      conclude;
    end
  end
  initial begin
    rst = 1'b1;
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 8'h00;
    wrData = 8'h00;
    lfsr = 16'h1A12;
    stIn = lfsr[7:0];
    wIn = lfsr[15:8];
    for (int pass = 0; pass < 2; pass++) begin
      doReset;
      outs;
      for (int a = 0; a < 256; a++) rd(8'(a));
    end
    wr(8'h71, 8'h5A);
    #1 chk("wordWr off", 32'(wWr), 32'h0);
    wr(8'h70, 8'h01);
    wr(8'h71, 8'hC3);
    #1 chk("wordWr", {wWr, wOut}, {1'b1, 8'hC3});
    rd(8'h71);
    chk("wordRd", 32'(wRd), 32'h1);
    for (int t = 0; t < 4; t++) begin
      fsTry = fsCodes[16*t +: 16];
      wr(8'h32, fsTry[15:8]);
      outs;
      wr(8'h33, fsTry[7:0]);
      outs;
    end
    for (int a = 0; a < 256; a++) begin
      lfsr = nxt(lfsr);
      wr(8'(a), lfsr[7:0]);
    end
    @(posedge ref_clk);
    stIn <= lfsr[15:8];
    wIn <= lfsr[7:0];
    outs;
    for (int a = 0; a < 256; a++) rd(8'(a));
    doReset;
    outs;
    conclude;
  end
endmodule // ccrb_reg_bank_tb
